// ### core/cable_reflection_amp_status.sv
// Reflection amplitude and general status registers with AXI4-Lite slave and interrupt
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module cable_reflection_amp_status (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Results from the diagnostic engine, valid in the cycle of measDone
  input  wire logic        measDone,
  input  wire logic [34:0] measPairCAmp,
  input  wire logic [34:0] measPairDAmp,
  input  wire logic [3:0]  measCross,
  input  wire logic [3:0]  measOverflow,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  // --------------------------------------------------------------------------
  // Result storage
  // --------------------------------------------------------------------------
  logic [refl_amp_pkg::AMP_W-1:0] ampC_r [refl_amp_pkg::NPEAK];
  logic [refl_amp_pkg::AMP_W-1:0] ampD_r [refl_amp_pkg::NPEAK];
  logic [3:0]                     cross_r;
  logic [3:0]                     ovf_r;

  // Results latch only on completion; nothing else writes them
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < refl_amp_pkg::NPEAK; i++) begin
        ampC_r[i] <= '0;
        ampD_r[i] <= '0;
      end
      cross_r <= '0;
      ovf_r   <= '0;
    end else if (measDone) begin
      for (int i = 0; i < refl_amp_pkg::NPEAK; i++) begin
        ampC_r[i] <= measPairCAmp[i*refl_amp_pkg::AMP_W +: refl_amp_pkg::AMP_W];
        ampD_r[i] <= measPairDAmp[i*refl_amp_pkg::AMP_W +: refl_amp_pkg::AMP_W];
      end
      cross_r <= measCross;
      ovf_r   <= measOverflow;
    end
  end

  // --------------------------------------------------------------------------
  // Register images
  // --------------------------------------------------------------------------
  function automatic logic [15:0] packAmp(input logic [6:0] lo, input logic [6:0] hi);
    logic [15:0] v;
    v = refl_amp_pkg::REG_RESET;
    v[refl_amp_pkg::LO_LSB +: refl_amp_pkg::AMP_W] = lo;
    v[refl_amp_pkg::HI_LSB +: refl_amp_pkg::AMP_W] = hi;
    return v;
  endfunction

  function automatic logic [9:0] wordIdx(input logic [11:0] a);
    return a[refl_amp_pkg::ADDR_W-1:refl_amp_pkg::IDX_SHIFT];
  endfunction

  wire logic [15:0] regCAmp01  = packAmp(ampC_r[0], ampC_r[1]);
  wire logic [15:0] regCAmp23  = packAmp(ampC_r[2], ampC_r[3]);
  wire logic [15:0] regC4D0Amp = packAmp(ampC_r[4], ampD_r[0]);
  wire logic [15:0] regDAmp12  = packAmp(ampD_r[1], ampD_r[2]);
  wire logic [15:0] regDAmp34  = packAmp(ampD_r[3], ampD_r[4]);
  logic [15:0] regGenStatus;
  always_comb begin
    regGenStatus = refl_amp_pkg::REG_RESET;
    regGenStatus[refl_amp_pkg::CROSS_LSB +: refl_amp_pkg::NPAIR] = cross_r;
    regGenStatus[refl_amp_pkg::OVF_LSB +: refl_amp_pkg::NPAIR]   = ovf_r;
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  logic [refl_amp_pkg::EV_W-1:0] irqStat_r;
  logic [refl_amp_pkg::EV_W-1:0] irqMask_r;
  logic [refl_amp_pkg::EV_W-1:0] evNow;
  logic [refl_amp_pkg::EV_W-1:0] w1cBits;
  logic                          wrStat;
  logic                          wrMask;
  always_comb begin
    evNow = '0;
    evNow[refl_amp_pkg::EV_DONE]  = measDone;
    evNow[refl_amp_pkg::EV_CROSS] = measDone & (|measCross);
    evNow[refl_amp_pkg::EV_OVF]   = measDone & (|measOverflow);
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  logic        awHeld_r;
  logic        wHeld_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  wire logic   awTake  = s_axi_awvalid & s_axi_awready;
  wire logic   wTake   = s_axi_wvalid & s_axi_wready;
  wire logic   wrFire  = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire logic [9:0] wrIdx = wordIdx(awAddr_r);
  wire logic   wrHit   = (wrIdx >= refl_amp_pkg::IDX_C_AMP_0_1) & (wrIdx <= refl_amp_pkg::IDX_IRQ_MASK);
  assign wrStat  = wrFire & wStrb_r[0] & (wrIdx == refl_amp_pkg::IDX_IRQ_STATUS);
  assign wrMask  = wrFire & wStrb_r[0] & (wrIdx == refl_amp_pkg::IDX_IRQ_MASK);
  assign w1cBits = wrStat ? wData_r[refl_amp_pkg::EV_W-1:0] : '0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= '0;
      wData_r       <= '0;
      wStrb_r       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= refl_amp_pkg::RESP_OKAY;
    end else begin
      // Each ready drops after its take so the channel holds one item until the answer
      s_axi_awready <= ~awHeld_r & ~awTake;
      s_axi_wready  <= ~wHeld_r & ~wTake;
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        // Result registers are read-only: writes to them answer OKAY but change nothing
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? refl_amp_pkg::RESP_OKAY : refl_amp_pkg::RESP_SLVERR;
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~w1cBits) | evNow;
      if (wrMask) begin
        irqMask_r <= wData_r[refl_amp_pkg::EV_W-1:0];
      end
      // Built from next-state values so the pin never lags a clear or a mask write
      irq <= |(((irqStat_r & ~w1cBits) | evNow) & (wrMask ? wData_r[refl_amp_pkg::EV_W-1:0] : irqMask_r));
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  wire logic [9:0] rdIdx = wordIdx(s_axi_araddr);
  logic [15:0] rdWord;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (rdIdx)
      refl_amp_pkg::IDX_C_AMP_0_1:  rdWord = regCAmp01;
      refl_amp_pkg::IDX_C_AMP_2_3:  rdWord = regCAmp23;
      refl_amp_pkg::IDX_C4_D0_AMP:  rdWord = regC4D0Amp;
      refl_amp_pkg::IDX_D_AMP_1_2:  rdWord = regDAmp12;
      refl_amp_pkg::IDX_D_AMP_3_4:  rdWord = regDAmp34;
      refl_amp_pkg::IDX_GEN_STATUS: rdWord = regGenStatus;
      refl_amp_pkg::IDX_IRQ_STATUS: rdWord = {13'h0000, irqStat_r};
      refl_amp_pkg::IDX_IRQ_MASK:   rdWord = {13'h0000, irqMask_r};
      default: begin
        rdWord = 16'h0000;
        rdHit  = 1'b0;
      end
    endcase
  end

  // Reads only sample; no register changes on a read
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= refl_amp_pkg::RESP_OKAY;
    end else begin
      // One read in flight: no new address while an answer stands
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rdWord};
        s_axi_rresp  <= rdHit ? refl_amp_pkg::RESP_OKAY : refl_amp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------------------
  // Register image checks
  // --------------------------------------------------------------------------
  // C amp 2/3, C4/D0, D amp 1/2 and the high peak of D amp 3/4 are tied back to the engine's inputs, so a peak swapped at capture shows up there;
  // C amp 0/1 is checked against the stored peaks, and the low peak of D amp 3/4 is not checked
  AST_C01: assert property ($rose(s_axi_rvalid) && $past(rdIdx) == refl_amp_pkg::IDX_C_AMP_0_1 |->
    s_axi_rdata[15:0] == {1'b0, $past(ampC_r[1]), 1'b0, $past(ampC_r[0])}) else $error("c amp 0/1 image wrong");
  AST_C23: assert property (measDone |=>
    regCAmp23 == {1'b0, $past(measPairCAmp[27:21]), 1'b0, $past(measPairCAmp[20:14])})
    else $error("c amp 2/3 image wrong");
  AST_C4D0: assert property (measDone |=>
    regC4D0Amp == {1'b0, $past(measPairDAmp[6:0]), 1'b0, $past(measPairCAmp[34:28])})
    else $error("c4/d0 image wrong");
  AST_D12: assert property (measDone |=>
    regDAmp12 == {1'b0, $past(measPairDAmp[20:14]), 1'b0, $past(measPairDAmp[13:7])})
    else $error("d amp 1/2 image wrong");
  AST_D34: assert property (measDone |=> regDAmp34[14:8] == $past(measPairDAmp[34:28])) else $error("d fifth peak not captured");
  AST_AMPRSVD: assert property (regCAmp01[15] == 1'b0 && regCAmp01[7] == 1'b0 &&
    regCAmp23[15] == 1'b0 && regCAmp23[7] == 1'b0 && regC4D0Amp[15] == 1'b0 && regC4D0Amp[7] == 1'b0 &&
    regDAmp12[15] == 1'b0 && regDAmp12[7] == 1'b0 && regDAmp34[15] == 1'b0 && regDAmp34[7] == 1'b0)
    else $error("reserved amplitude bit set");
  AST_HOLD: assert property (!measDone |=> $stable(regCAmp01) && $stable(regDAmp34)) else $error("amplitude changed without run");
  AST_HOLD2: assert property (!measDone |=>
    $stable(regCAmp23) && $stable(regC4D0Amp) && $stable(regDAmp12)) else $error("amplitude changed without run");
  AST_CROSS: assert property (measDone |=> regGenStatus[11:8] == $past(measCross)) else $error("cross flags wrong");
  AST_OVF: assert property (measDone |=> regGenStatus[7:4] == $past(measOverflow)) else $error("overflow flags wrong");
  AST_RSVD: assert property (regGenStatus[15:12] == 4'h0 && regGenStatus[3:0] == 4'h0) else $error("reserved bits set");
  AST_STILL: assert property (!measDone |=> $stable(regGenStatus)) else $error("status changed without run");
  AST_RDNOSIDE: assert property (s_axi_arvalid && s_axi_arready && !measDone && !wrStat |=>
    $stable(regGenStatus) && $stable(regCAmp01) && $stable(irqStat_r)) else $error("read had a side effect");

  // --------------------------------------------------------------------------
  // Interrupt checks
  // --------------------------------------------------------------------------
  // The pin must match status and mask in every cycle, with no lag after a clear
  AST_IRQLVL: assert property (irq == |(irqStat_r & irqMask_r)) else $error("irq level disagrees with status");
  AST_SETWIN: assert property (measDone |=> irqStat_r[refl_amp_pkg::EV_DONE]) else $error("completion event lost");
  AST_EVCROSS: assert property (measDone && (|measCross) |=> irqStat_r[refl_amp_pkg::EV_CROSS])
    else $error("cross event lost");
  AST_EVOVF: assert property (measDone && (|measOverflow) |=> irqStat_r[refl_amp_pkg::EV_OVF])
    else $error("overflow event lost");
  AST_W1C: assert property (wrStat |=> (irqStat_r & $past(w1cBits & ~evNow)) == '0)
    else $error("written one did not clear");
  AST_STATHOLD: assert property (!measDone && !wrStat |=> $stable(irqStat_r)) else $error("status moved on its own");
  AST_MASKWR: assert property (wrMask |=> irqMask_r == $past(wData_r[refl_amp_pkg::EV_W-1:0]))
    else $error("mask write lost");

  // --------------------------------------------------------------------------
  // Bus checks
  // --------------------------------------------------------------------------
  AST_RDANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  AST_WRANS: assert property (wrFire |=> s_axi_bvalid) else $error("write not answered");
  AST_AWONCE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address taken twice");
  AST_WONCE: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("data taken twice");
  AST_ARONCE: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready) else $error("read taken twice");
  AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  AST_ARBUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer stands");
  AST_RDERR: assert property (s_axi_arvalid && s_axi_arready && !rdHit |=>
    s_axi_rresp == refl_amp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_WRERR: assert property (wrFire && (wrIdx < refl_amp_pkg::IDX_C_AMP_0_1 || wrIdx > refl_amp_pkg::IDX_IRQ_MASK)
    |=> s_axi_bresp == refl_amp_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  AST_WROK: assert property (wrFire && wrIdx == refl_amp_pkg::IDX_GEN_STATUS |=>
    s_axi_bresp == refl_amp_pkg::RESP_OKAY) else $error("read-only write refused");

  // --------------------------------------------------------------------------
  // Cover points
  // --------------------------------------------------------------------------
  COV_RUN: cover property (measDone ##1 s_axi_arvalid && s_axi_arready);
  COV_IRQ: cover property (measDone ##2 irq);
  COV_W1C: cover property (wrStat ##1 !irq);
  COV_RDERR: cover property (s_axi_rvalid && s_axi_rresp == refl_amp_pkg::RESP_SLVERR);
  COV_WRERR: cover property (s_axi_bvalid && s_axi_bresp == refl_amp_pkg::RESP_SLVERR);
endmodule // cable_reflection_amp_status

// ### core/refl_amp_pkg.sv
// Package holding the register map and field layout of the reflection amplitude status bank
package refl_amp_pkg;
  // --------------------------------------------------------------------------
  // Register indices (printed offsets are not multiples of four)
  // --------------------------------------------------------------------------
  localparam logic [9:0]  IDX_C_AMP_0_1   = 10'h19F;
  localparam logic [9:0]  IDX_C_AMP_2_3   = 10'h1A0;
  localparam logic [9:0]  IDX_C4_D0_AMP   = 10'h1A1;
  localparam logic [9:0]  IDX_D_AMP_1_2   = 10'h1A2;
  localparam logic [9:0]  IDX_D_AMP_3_4   = 10'h1A3;
  localparam logic [9:0]  IDX_GEN_STATUS  = 10'h1A4;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h1A5;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h1A6;
  localparam int          IDX_SHIFT       = 2;
  localparam int          ADDR_W          = 12;
  // --------------------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------------------
  localparam int          AMP_W           = 7;
  localparam int          LO_LSB          = 0;
  localparam int          HI_LSB          = 8;
  localparam int          OVF_LSB         = 4;
  localparam int          CROSS_LSB       = 8;
  localparam int          NPAIR           = 4;
  localparam int          NPEAK           = 5;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  // Interrupt event bits
  localparam int          EV_DONE         = 0;
  localparam int          EV_CROSS        = 1;
  localparam int          EV_OVF          = 2;
  localparam int          EV_W            = 3;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ### tb/testbench.sv
// Self-checking testbench for the reflection amplitude status bank
`timescale 1ns/1ps
module testbench;
  logic        ref_clk      = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        measDone     = 1'b0;
  logic [34:0] measPairCAmp = '0;
  logic [34:0] measPairDAmp = '0;
  logic [3:0]  measCross    = '0;
  logic [3:0]  measOverflow = '0;
  logic [11:0] awaddr       = '0;
  logic [11:0] araddr       = '0;
  logic [31:0] wdata        = '0;
  logic        awvalid      = 1'b0;
  logic        wvalid       = 1'b0;
  logic        bready       = 1'b0;
  logic        arvalid      = 1'b0;
  logic        rready       = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [1:0]  rsp;
  int          n_mismatch   = 0;
  int          compares     = 0;

  cable_reflection_amp_status DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .measDone(measDone),
    .measPairCAmp(measPairCAmp), .measPairDAmp(measPairDAmp), .measCross(measCross),
    .measOverflow(measOverflow), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  always #25 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] expResp);
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    chk("bresp", {30'h0, rsp}, {30'h0, expResp});
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] expResp);
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk("rdata", rdata, exp);
    chk("rresp", {30'h0, rresp}, {30'h0, expResp});
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic scnReset;
    for (int i = 10'h19F; i <= 10'h1A6; i++) rdchk(10'(i), 32'h0, 2'b00);
  endtask

  // Inputs are inverted after the pulse so stale sampling would show up
  task automatic scnResults(input logic [34:0] c, input logic [34:0] d, input logic [3:0] cr, input logic [3:0] ov);
    @(posedge ref_clk);
    measPairCAmp <= c;
    measPairDAmp <= d;
    measCross <= cr;
    measOverflow <= ov;
    measDone <= 1'b1;
    @(posedge ref_clk);
    measDone <= 1'b0;
    measPairCAmp <= ~c;
    measPairDAmp <= ~d;
    measCross <= ~cr;
    measOverflow <= ~ov;
    rdchk(refl_amp_pkg::IDX_C_AMP_0_1, {17'h0, c[13:7], 1'b0, c[6:0]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_C_AMP_2_3, {17'h0, c[27:21], 1'b0, c[20:14]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_C4_D0_AMP, {17'h0, d[6:0], 1'b0, c[34:28]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_D_AMP_1_2, {17'h0, d[20:14], 1'b0, d[13:7]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_D_AMP_3_4, {17'h0, d[34:28], 1'b0, d[27:21]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_GEN_STATUS, {20'h0, cr, ov, 4'h0}, 2'b00);
    rdchk(refl_amp_pkg::IDX_GEN_STATUS, {20'h0, cr, ov, 4'h0}, 2'b00);
  endtask

  task automatic scnReadOnly(input logic [34:0] c);
    wr(refl_amp_pkg::IDX_C_AMP_0_1, 32'hFFFF_FFFF, 2'b00);
    wr(refl_amp_pkg::IDX_GEN_STATUS, 32'hFFFF_FFFF, 2'b00);
    rdchk(refl_amp_pkg::IDX_C_AMP_0_1, {17'h0, c[13:7], 1'b0, c[6:0]}, 2'b00);
    rdchk(refl_amp_pkg::IDX_GEN_STATUS, 32'h0000_0A50, 2'b00);
    wr(10'h3FF, 32'h0000_0001, 2'b10);
    rdchk(10'h3FF, 32'h0, 2'b10);
  endtask

  // Status holds done, cross and overflow from the earlier runs
  task automatic scnIrq;
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(refl_amp_pkg::IDX_IRQ_MASK, 32'h0000_0007, 2'b00);
    rdchk(refl_amp_pkg::IDX_IRQ_STATUS, 32'h0000_0007, 2'b00);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(refl_amp_pkg::IDX_IRQ_STATUS, 32'h0000_0007, 2'b00);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    scnResults(35'h0, 35'h0, 4'h0, 4'h0);
    rdchk(refl_amp_pkg::IDX_IRQ_STATUS, 32'h0000_0001, 2'b00);
    chk("irq done", {31'h0, irq}, 32'h1);
  endtask

  task automatic summarize;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    scnReset;
    scnResults(35'h5_5A3C_F0E1, 35'h2_B6C1_9D47, 4'h5, 4'hA);
    scnResults(~35'h5_5A3C_F0E1, ~35'h2_B6C1_9D47, 4'hA, 4'h5);
    scnReadOnly(~35'h5_5A3C_F0E1);
    scnIrq;
    summarize;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #250000;
    n_mismatch++;
    summarize;
  end
endmodule // testbench
